// [src/amx_pkg.sv]
package amx_pkg;
    localparam int N_HW   = 18;
    localparam int N_SRC  = 36;
    localparam int N_OUT  = 18;
    localparam int N_MTR  = N_SRC + N_OUT;
    localparam int N_SUBMIX = N_OUT / 2;
    // Register offsets (word addresses on the register port)
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_HOLD = 12'h001;
    localparam logic [11:0] A_THR  = 12'h002;
    localparam logic [11:0] A_DISP = 12'h003;
    localparam logic [11:0] A_READ = 12'h004;
    localparam logic [11:0] A_STAT = 12'h005;
    localparam logic [11:0] A_OCLR = 12'h006;
    localparam logic [11:0] A_TPOS = 12'h007;
    localparam logic [11:0] A_CH   = 12'h040;
    localparam logic [11:0] A_OUT  = 12'h080;
    localparam logic [11:0] A_REC  = 12'h0a0;
    localparam logic [11:0] A_PEAK = 12'h100;
    localparam logic [11:0] A_RMS  = 12'h140;
    localparam logic [11:0] A_GAIN = 12'h800;
    // Field positions
    localparam int CTRL_TRIM = 0;
    localparam int CTRL_RMS  = 1;
    localparam int CTRL_RPP  = 2;
    localparam int CTRL_REF  = 3;
    localparam int CH_MUTE   = 8;
    localparam int CH_SOLO   = 9;
    localparam int CH_MONO   = 10;
    localparam int CH_TRIM   = 11;
    localparam int OUT_LOOP  = 8;
    // Reset values and arithmetic constants
    localparam logic [15:0] HOLD_RST   = 16'h0100;
    localparam logic [22:0] THR_RST    = 23'h7fffff;
    localparam logic [7:0]  PAN_CENTRE = 8'h80;
    localparam logic [7:0]  UNITY      = 8'he8;
    localparam logic [16:0] Q14_ONE    = 17'h04000;
    localparam logic [8:0]  PAN_SPAN   = 9'h100;
    localparam logic [7:0]  PAN_SLOPE  = 8'hb5;
    localparam int MS_SHIFT = 6;
    localparam int PK_DECAY = 3;
    // Readout refresh: time, clock rate, derived cycles
    localparam int READOUT_MS     = 500;
    localparam int CLK_HZ         = 10_000_000;
    localparam int READOUT_CYCLES = READOUT_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {ST_IDLE, ST_MIX, ST_FIN} amx_state_type;

    typedef struct packed {
        amx_state_type                   st;
        logic [5:0]                      si;
        logic [4:0]                      oi;
        logic signed [33:0]              acc;
        logic [N_SRC-1:0][N_OUT-1:0][7:0] gain;
        logic [N_SRC-1:0][11:0]          ch;
        logic [N_OUT-1:0][8:0]           oc;
        logic [N_HW-1:0][7:0]            rg;
        logic [N_SRC-1:0][23:0]          smp;
        logic [3:0]                      ctrl;
        logic [15:0]                     hold;
        logic [22:0]                     thr;
        logic [5:0]                      disp;
        logic [N_MTR-1:0][23:0]          pk;
        logic [N_MTR-1:0][15:0]          hc;
        logic [N_MTR-1:0][31:0]          ms;
        logic [N_MTR-1:0]                overload_indicator;
        logic [24:0]                     rdout;
        logic [22:0]                     tick;
        logic                            lp_v;
        logic [4:0]                      lp_c;
        logic [23:0]                     lp_d;
        logic [31:0]                     rdata;
        logic                            out_v;
        logic [4:0]                      out_c;
        logic [23:0]                     out_d;
        logic                            rec_v;
        logic [4:0]                      rec_c;
        logic [23:0]                     rec_d;
    } amx_regs_type;
endpackage : amx_pkg

// [src/amx_mixer.sv]
`timescale 1ns/10ps
module amx_mixer #(
    parameter int READOUT_CYCLES = amx_pkg::READOUT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        in_valid,
    input  wire logic [5:0]  in_chan,
    input  wire logic [23:0] in_data,
    input  wire logic        frame_start,
    output logic             out_valid,
    output logic      [4:0]  out_chan,
    output logic      [23:0] out_data,
    output logic             rec_valid,
    output logic      [4:0]  rec_chan,
    output logic      [23:0] rec_data
);
    import amx_pkg::*;

    amx_regs_type r;
    amx_regs_type n;

    logic               solo_any;
    logic [7:0]         tpos;
    logic [7:0]         cur_g;
    logic [11:0]        cur_ch;
    logic               pass;
    logic signed [42:0] prod1;
    logic [14:0]        pf;
    logic signed [43:0] prod2;
    logic signed [52:0] yfull;
    logic [23:0]        ysat;
    logic signed [42:0] rprod;
    logic [23:0]        a_s;
    logic [23:0]        a_o;
    logic [31:0]        q_s;
    logic [31:0]        q_o;
    logic [5:0]         s_w;
    logic [4:0]         o_w;
    logic signed [9:0]  delta;
    logic [15:0]        rm;
    logic [16:0]        rref;

    // Gain code to linear Q15: 0 is silence, 8 codes per 6 dB
    function automatic logic [17:0] gain_lin(input logic [7:0] c);
        logic [15:0] m;
        logic [19:0] t;
        case (c[2:0])
            3'h0: m = 16'h8000;
            3'h1: m = 16'h8b96;
            3'h2: m = 16'h9838;
            3'h3: m = 16'ha5ff;
            3'h4: m = 16'hb505;
            3'h5: m = 16'hc567;
            3'h6: m = 16'hd745;
            default: m = 16'heac1;
        endcase
        t = {2'b00, m, 2'b00};
        return (c == 8'h00) ? 18'h00000 : 18'(t >> (5'd31 - c[7:3]));
    endfunction : gain_lin

    // Pan factor Q14, clipped at one; product widened so it cannot wrap
    function automatic logic [14:0] pan_fac(input logic [8:0] d);
        logic [16:0] p;
        p = 17'((17'(d) * 17'(PAN_SLOPE)) >> 1);
        return (p > Q14_ONE) ? 15'(Q14_ONE) : 15'(p);
    endfunction : pan_fac

    // Integer square root, one result bit per step
    function automatic logic [15:0] isqrt(input logic [31:0] v);
        logic [15:0] r;
        logic [15:0] t;
        r = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            t = r | (16'h0001 << i);
            if (32'(t) * 32'(t) <= v) r = t;
        end
        return r;
    endfunction : isqrt

    // Clamp to the 24-bit signed range
    function automatic logic [23:0] sat24(input logic signed [37:0] v);
        if (v > 38'sh00007fffff) return 24'h7fffff;
        if (v < -38'sh0000800000) return 24'h800000;
        return v[23:0];
    endfunction : sat24

    // Solo scan and trim position of the displayed channel
    always_comb begin
        solo_any = 1'b0;
        tpos     = 8'h00;
        for (int i = 0; i < N_SRC; i++) begin
            solo_any = solo_any | r.ch[i][CH_SOLO];
        end
        if (r.disp < 6'(N_SRC)) begin
            for (int k = 0; k < N_OUT; k++) begin
                if (r.gain[r.disp][k] > tpos) tpos = r.gain[r.disp][k];
            end
        end
    end

    // Crosspoint multiply for the current source and output
    assign cur_g  = r.gain[r.si][r.oi];
    assign cur_ch = r.ch[r.si];
    assign pass   = (cur_g != 8'h00) && !cur_ch[CH_MUTE]
                    && !(solo_any && !cur_ch[CH_SOLO])
                    && !(!cur_ch[CH_MONO] && (r.si[0] != r.oi[0]));
    assign prod1  = $signed(r.smp[r.si]) * $signed({1'b0, gain_lin(cur_g)});
    assign pf     = pan_fac(r.oi[0] ? {1'b0, cur_ch[7:0]}
                                    : PAN_SPAN - {1'b0, cur_ch[7:0]});
    assign prod2  = $signed(prod1[42:15]) * $signed({1'b0, pf});

    // Output gain and saturation
    assign yfull = r.acc * $signed({1'b0, gain_lin(r.oc[r.oi][7:0])});
    assign ysat  = sat24(yfull[52:15]);

    // Record path gain when record processing is on
    assign rprod = $signed(in_data) * $signed({1'b0, gain_lin(r.rg[in_chan[4:0]])});

    // Magnitude and scaled square for both meter ports
    assign a_s = in_data[23] ? ((in_data == 24'h800000) ? 24'h7fffff : -in_data) : in_data;
    assign a_o = ysat[23] ? ((ysat == 24'h800000) ? 24'h7fffff : -ysat) : ysat;
    assign q_s = 32'((48'(a_s) * 48'(a_s)) >> 16);
    assign q_o = 32'((48'(a_o) * 48'(a_o)) >> 16);

    // Gain write decode and trim step
    assign s_w   = reg_addr[10:5];
    assign o_w   = reg_addr[4:0];
    assign delta = 10'(reg_wdata[7:0]) - 10'(r.gain[s_w][o_w]);

    // RMS of displayed meter, optionally referenced up by 3 dB
    assign rm   = isqrt(r.ms[r.disp]);
    assign rref = 17'((25'(rm) * 25'(PAN_SLOPE)) >> 7);

    // Next-state logic
    always_comb begin
        logic [5:0]        mi;
        logic [23:0]       v;
        logic [31:0]       q;
        logic signed [9:0] t;
        mi = 6'h00;
        v  = 24'h000000;
        q  = 32'h00000000;
        t  = 10'sh000;
        n       = r;
        n.out_v = 1'b0;
        n.rec_v = 1'b0;
        n.rdata = 32'h00000000;

        // Register writes
        if (reg_wr) begin
            if (reg_addr == A_CTRL) begin
                n.ctrl = reg_wdata[3:0];
            end else if (reg_addr == A_HOLD) begin
                n.hold = reg_wdata[15:0];
            end else if (reg_addr == A_THR) begin
                n.thr = reg_wdata[22:0];
            end else if (reg_addr == A_DISP) begin
                n.disp = reg_wdata[5:0];
            end else if (reg_addr == A_OCLR) begin
                if (reg_wdata[5:0] < 6'(N_MTR)) n.overload_indicator[reg_wdata[5:0]] = 1'b0;
            end else if (reg_addr[11:6] == A_CH[11:6] && reg_addr[5:0] < 6'(N_SRC)) begin
                n.ch[reg_addr[5:0]] = reg_wdata[11:0];
            end else if (reg_addr[11:5] == A_OUT[11:5] && reg_addr[4:0] < 5'(N_OUT)) begin
                n.oc[reg_addr[4:0]] = reg_wdata[8:0];
            end else if (reg_addr[11:5] == A_REC[11:5] && reg_addr[4:0] < 5'(N_HW)) begin
                n.rg[reg_addr[4:0]] = reg_wdata[7:0];
            end else if (reg_addr[11] && s_w < 6'(N_SRC) && o_w < 5'(N_OUT)) begin
                if ((r.ctrl[CTRL_TRIM] || r.ch[s_w][CH_TRIM])
                    && r.gain[s_w][o_w] != 8'h00 && reg_wdata[7:0] != 8'h00) begin
                    for (int k = 0; k < N_OUT; k++) begin
                        if (r.gain[s_w][k] != 8'h00) begin
                            t = 10'(r.gain[s_w][k]) + delta;
                            if (t < 10'sh001) n.gain[s_w][k] = 8'h01;
                            else if (t > 10'sh0ff) n.gain[s_w][k] = 8'hff;
                            else n.gain[s_w][k] = t[7:0];
                        end
                    end
                end else begin
                    n.gain[s_w][o_w] = reg_wdata[7:0];
                end
            end
        end

        // Register reads, data in the next cycle
        if (reg_rd) begin
            if (reg_addr == A_CTRL) begin
                n.rdata = {28'h0000000, r.ctrl};
            end else if (reg_addr == A_HOLD) begin
                n.rdata = {16'h0000, r.hold};
            end else if (reg_addr == A_THR) begin
                n.rdata = {9'h000, r.thr};
            end else if (reg_addr == A_DISP) begin
                n.rdata = {26'h0000000, r.disp};
            end else if (reg_addr == A_READ) begin
                n.rdata = {7'h00, r.rdout};
            end else if (reg_addr == A_STAT) begin
                n.rdata = {31'h00000000, r.st != ST_IDLE};
            end else if (reg_addr == A_TPOS) begin
                n.rdata = {24'h000000, tpos};
            end else if (reg_addr[11:6] == A_CH[11:6] && reg_addr[5:0] < 6'(N_SRC)) begin
                n.rdata = {20'h00000, r.ch[reg_addr[5:0]]};
            end else if (reg_addr[11:5] == A_OUT[11:5] && reg_addr[4:0] < 5'(N_OUT)) begin
                n.rdata = {23'h000000, r.oc[reg_addr[4:0]]};
            end else if (reg_addr[11:5] == A_REC[11:5] && reg_addr[4:0] < 5'(N_HW)) begin
                n.rdata = {24'h000000, r.rg[reg_addr[4:0]]};
            end else if (reg_addr[11:6] == A_PEAK[11:6] && reg_addr[5:0] < 6'(N_MTR)) begin
                n.rdata = {7'h00, r.overload_indicator[reg_addr[5:0]], r.pk[reg_addr[5:0]]};
            end else if (reg_addr[11:6] == A_RMS[11:6] && reg_addr[5:0] < 6'(N_MTR)) begin
                n.rdata = r.ms[reg_addr[5:0]];
            end else if (reg_addr[11] && s_w < 6'(N_SRC) && o_w < 5'(N_OUT)) begin
                n.rdata = {24'h000000, r.gain[s_w][o_w]};
            end
        end

        // Latest sample of each source
        if (in_valid && in_chan < 6'(N_SRC)) n.smp[in_chan] = in_data;

        // Mix sequencer: per output, 36 crosspoint cycles then one finish cycle
        case (r.st)
            ST_IDLE: begin
                if (frame_start) begin
                    n.st  = ST_MIX;
                    n.si  = 6'h00;
                    n.oi  = 5'h00;
                    n.acc = 34'sh0;
                end
            end
            ST_MIX: begin
                if (pass) n.acc = r.acc + 34'($signed(prod2[43:14]));
                if (r.si == 6'(N_SRC - 1)) n.st = ST_FIN;
                else n.si = r.si + 6'h01;
            end
            ST_FIN: begin
                n.out_v = 1'b1;
                n.out_c = r.oi;
                n.out_d = ysat;
                if (r.oc[r.oi][OUT_LOOP]) begin
                    n.lp_v = 1'b1;
                    n.lp_c = r.oi;
                    n.lp_d = ysat;
                end
                n.acc = 34'sh0;
                n.si  = 6'h00;
                if (r.oi == 5'(N_OUT - 1)) begin
                    n.st = ST_IDLE;
                end else begin
                    n.oi = r.oi + 5'h01;
                    n.st = ST_MIX;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        // Record port: live input first, pending loopback word otherwise
        if (in_valid && in_chan < 6'(N_HW) && !r.oc[in_chan[4:0]][OUT_LOOP]) begin
            n.rec_v = 1'b1;
            n.rec_c = in_chan[4:0];
            n.rec_d = r.ctrl[CTRL_RPP] ? sat24(38'($signed(rprod[42:15]))) : in_data;
        end else if (r.lp_v) begin
            n.rec_v = 1'b1;
            n.rec_c = r.lp_c;
            n.rec_d = r.lp_d;
            n.lp_v  = (r.st == ST_FIN) && r.oc[r.oi][OUT_LOOP];
        end

        // Meters: decay per frame, then update on a new sample
        for (int i = 0; i < N_MTR; i++) begin
            if (frame_start) begin
                if (r.hc[i] != 16'h0000) n.hc[i] = r.hc[i] - 16'h0001;
                else n.pk[i] = r.pk[i] - (r.pk[i] >> PK_DECAY);
            end
            mi = 6'(i);
            if ((in_valid && in_chan == mi)
                || (r.st == ST_FIN && 6'(N_SRC) + {1'b0, r.oi} == mi)) begin
                v = (in_valid && in_chan == mi) ? a_s : a_o;
                q = (in_valid && in_chan == mi) ? q_s : q_o;
                if (v >= n.pk[i]) begin
                    n.pk[i] = v;
                    n.hc[i] = r.hold;
                end
                n.ms[i] = r.ms[i] - (r.ms[i] >> MS_SHIFT) + (q >> MS_SHIFT);
                if (v >= {1'b0, r.thr}) n.overload_indicator[i] = 1'b1;
            end
        end

        // Readout latch every half second
        if (r.tick >= 23'(READOUT_CYCLES - 1)) begin
            n.tick = 23'h000000;
            if (r.disp < 6'(N_MTR)) begin
                if (r.ctrl[CTRL_RMS]) begin
                    n.rdout = {r.overload_indicator[r.disp], 24'h000000};
                    if (!r.ctrl[CTRL_REF]) n.rdout[23:8] = rm;
                    else if (rref[16]) n.rdout[23:8] = 16'hffff;
                    else n.rdout[23:8] = rref[15:0];
                end else begin
                    n.rdout = {r.overload_indicator[r.disp], r.pk[r.disp]};
                end
            end
        end else begin
            n.tick = r.tick + 23'h000001;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r      <= '0;
            r.st   <= ST_IDLE;
            r.hold <= HOLD_RST;
            r.thr  <= THR_RST;
            for (int i = 0; i < N_SRC; i++) begin
                r.ch[i][7:0] <= PAN_CENTRE;
            end
            for (int k = 0; k < N_OUT; k++) begin
                r.oc[k][7:0] <= UNITY;
            end
            for (int k = 0; k < N_HW; k++) begin
                r.rg[k] <= UNITY;
            end
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = r.rdata;
    assign out_valid = r.out_v;
    assign out_chan  = r.out_c;
    assign out_data  = r.out_d;
    assign rec_valid = r.rec_v;
    assign rec_chan  = r.rec_c;
    assign rec_data  = r.rec_d;
endmodule : amx_mixer

// [testbench/amx_src_model.sv]
`timescale 1ns/10ps
module amx_src_model (
    input  wire logic        mclk,
    output logic             in_valid,
    output logic      [5:0]  in_chan,
    output logic      [23:0] in_data
);
    // Quiet source lines at time zero
    initial begin
        in_valid = 1'b0;
        in_chan  = 6'h00;
        in_data  = 24'h000000;
    end

    // One sample after an idle gap; released lines show inverted values
    task automatic send(input logic [5:0] ch, input logic [23:0] d, input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        in_valid <= 1'b1;
        in_chan  <= ch;
        in_data  <= d;
        @(posedge mclk);
        in_valid <= 1'b0;
        in_chan  <= ~ch;
        in_data  <= ~d;
    endtask : send
endmodule : amx_src_model

// [testbench/amx_mixer_chk.sv]
`timescale 1ns/10ps
module amx_mixer_chk
    import amx_pkg::*;
#(
    parameter int READOUT_CYCLES = 64
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        in_valid,
    input wire logic [5:0]  in_chan,
    input wire logic [23:0] in_data,
    input wire logic        frame_start,
    input wire logic        out_valid,
    input wire logic [4:0]  out_chan,
    input wire logic [23:0] out_data,
    input wire logic        rec_valid,
    input wire logic [4:0]  rec_chan,
    input wire logic [23:0] rec_data
);
    logic [9:0]       cnt_reg;
    logic             rpp_reg;
    logic [N_OUT-1:0] loop_reg;

    // Mix pass window and shadow of record path settings
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_reg  <= 10'h000;
            rpp_reg  <= 1'b0;
            loop_reg <= '0;
        end else begin
            if (cnt_reg != 10'h000)
                cnt_reg <= cnt_reg - 10'h001;
            else if (frame_start)
                cnt_reg <= 10'h29c;
            if (reg_wr && reg_addr == A_CTRL)
                rpp_reg <= reg_wdata[CTRL_RPP];
            if (reg_wr && reg_addr >= A_OUT && reg_addr < A_OUT + 12'h012)
                loop_reg[reg_addr[4:0]] <= reg_wdata[OUT_LOOP];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Steps of one mix pass
    sequence s_first_out;
        ##38 out_valid && out_chan == 5'h00;
    endsequence
    sequence s_next_out;
        ##37 out_valid && out_chan == $past(out_chan) + 5'h01;
    endsequence

    a_pass_start: assert property (frame_start && cnt_reg == 10'h000 |-> s_first_out)
        else $error("first output not at its slot");
    a_chan_step: assert property (out_valid && out_chan < 5'h11 |-> s_next_out)
        else $error("next output missing or out of order");
    a_out_gap: assert property (out_valid |=> !out_valid [*8])
        else $error("output pulses too close");
    a_out_range: assert property (out_valid |-> out_chan < 5'h12 && cnt_reg != 10'h000)
        else $error("output outside a pass or range");
    a_rec_bypass: assert property (in_valid && in_chan < 6'h12 && !rpp_reg
        && !loop_reg[in_chan[4:0]] |=> rec_valid && 6'(rec_chan) == $past(in_chan)
        && rec_data == $past(in_data))
        else $error("record word altered or missing");
    a_loop_block: assert property (in_valid && in_chan < 6'h12
        && loop_reg[in_chan[4:0]] && cnt_reg == 10'h000 |=> !rec_valid)
        else $error("loopback input was recorded");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data outside its cycle");
    a_rdata_unmapped: assert property (reg_rd && reg_addr == 12'h0ff |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : amx_mixer_chk

bind amx_mixer amx_mixer_chk #(.READOUT_CYCLES(READOUT_CYCLES)) u_chk (.mclk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_chan, .in_data,
    .frame_start, .out_valid, .out_chan, .out_data, .rec_valid, .rec_chan, .rec_data);

// [testbench/amx_mixer_bench.sv]
`timescale 1ns/10ps
module amx_mixer_bench;
    import amx_pkg::*;
    localparam int RC = 64;
    logic        mclk;
    logic        rst_n;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        in_valid;
    logic [5:0]  in_chan;
    logic [23:0] in_data;
    logic        frame_start;
    logic        out_valid;
    logic [4:0]  out_chan;
    logic [23:0] out_data;
    logic        rec_valid;
    logic [4:0]  rec_chan;
    logic [23:0] rec_data;
    int          fail_count;
    int          num_checks;
    int          lb;
    logic [23:0] got [N_OUT];

    amx_mixer #(.READOUT_CYCLES(RC)) dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .in_valid, .in_chan, .in_data, .frame_start, .out_valid,
        .out_chan, .out_data, .rec_valid, .rec_chan, .rec_data);
    amx_src_model src (.mclk, .in_valid, .in_chan, .in_data);

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd

    // Record word seen one cycle after the sample
    task automatic chk_rec(input logic [5:0] c, input logic [23:0] d);
        src.send(c, d, 0);
        #1;
        chk(32'({rec_valid, rec_chan}), 32'({1'b1, c[4:0]}));
    endtask : chk_rec

    // One mix pass, optionally with a refused start in mid-pass
    task automatic run_frame(input logic poke);
        int n = 0;
        int k = 0;
        @(posedge mclk);
        frame_start <= 1'b1;
        @(posedge mclk);
        frame_start <= 1'b0;
        while (n < N_OUT && k < 900) begin
            @(posedge mclk);
            k++;
            frame_start <= poke && k == 200;
            if (rec_valid === 1'b1 && rec_chan === 5'h03)
                lb++;
            if (out_valid === 1'b1) begin
                got[out_chan] = out_data;
                n++;
            end
        end
        if (n != N_OUT) begin
            fail_count++;
            $display("Error at %0t: mix pass timed out", $time);
            end_sim();
        end
        repeat (10) @(posedge mclk);
    endtask : run_frame

    task automatic check_mix(input logic [23:0] a, input logic [23:0] b, input logic [23:0] c);
        for (int o = 0; o < N_OUT; o++)
            chk(32'(got[o]), 32'(o == 0 ? a : o == 2 ? b : (o == 4 || o == 5) ? c : 24'h0));
    endtask : check_mix

    // Free running clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Main sequence
    initial begin
        rst_n       = 1'b0;
        reg_addr    = 12'h000;
        reg_wdata   = 32'h0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        frame_start = 1'b0;
        fail_count  = 0;
        num_checks  = 0;
        lb          = 0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(A_HOLD, 32'h100);
        rd(A_THR, 32'h7fffff);
        rd(A_CH, 32'h80);
        rd(A_OUT + 12'h011, 32'he8);
        wr(12'h0ff, 32'hffffffff);
        rd(12'h0ff, 32'h0);
        wr(A_HOLD, 32'h2);
        chk_rec(6'h03, 24'h7fffff);
        chk(32'(rec_data), 32'h7fffff);
        rd(A_PEAK + 12'h003, 32'h017fffff);
        wr(A_OCLR, 32'h3);
        rd(A_PEAK + 12'h003, 32'h007fffff);
        wr(A_THR, 32'h400000);
        src.send(6'h04, 24'hc00000, 3);
        rd(A_PEAK + 12'h004, 32'h01400000);
        wr(A_CTRL, 32'h4);
        wr(A_REC + 12'h003, 32'hf0);
        chk_rec(6'h03, 24'h001000);
        chk(32'(rec_data), 32'h002000);
        wr(A_CTRL, 32'h0);
        wr(A_OUT + 12'h003, 32'h1e8);
        src.send(6'h03, 24'h000123, 0);
        #1;
        chk(32'(rec_valid), 32'h0);
        // Routing set up ahead of the pass
        wr(A_CH, 32'h400);
        wr(A_CH + 12'h012, 32'h480);
        wr(A_GAIN, 32'he8);
        wr(A_GAIN + 12'h001, 32'he8);
        wr(A_GAIN + 12'h002, 32'he0);
        wr(A_GAIN + 12'h244, 32'he8);
        wr(A_GAIN + 12'h245, 32'he8);
        src.send(6'h00, 24'h100000, 0);
        src.send(6'h12, 24'h100000, 2);
        run_frame(1'b1);
        check_mix(24'h100000, 24'h080000, 24'h0b5000);
        chk(32'(lb), 32'h1);
        rd(A_PEAK, 32'h100000);
        rd(A_PEAK + 12'h026, 32'h080000);
        wr(A_DISP, 32'h24);
        repeat (2 * RC) @(posedge mclk);
        rd(A_READ, 32'h00100000);
        wr(A_CH + 12'h012, 32'h680);
        run_frame(1'b0);
        check_mix(24'h0, 24'h0, 24'h0b5000);
        rd(A_PEAK, 32'h0e0000);
        wr(A_CH + 12'h012, 32'h580);
        run_frame(1'b0);
        check_mix(24'h100000, 24'h080000, 24'h0);
        wr(A_CTRL, 32'h1);
        wr(A_GAIN, 32'hf0);
        rd(A_GAIN + 12'h002, 32'he8);
        rd(A_GAIN + 12'h003, 32'h0);
        wr(A_DISP, 32'h0);
        rd(A_TPOS, 32'hf0);
        run_frame(1'b0);
        check_mix(24'h200000, 24'h100000, 24'h0);
        rd(A_STAT, 32'h0);
        rd(A_RMS + 12'h004, 32'h400000);
        wr(A_CTRL, 32'ha);
        wr(A_DISP, 32'h4);
        repeat (2 * RC) @(posedge mclk);
        rd(A_READ, 32'h010b5000);
        end_sim();
    end
endmodule : amx_mixer_bench
